// [hdl/mpo_pkg.sv]
// Purpose: Shared constants and types for the multipurpose output port.
// Assumes: AHB-Lite register bus, 32-bit data, one word per register.
// Notes: Offsets are byte addresses.
package mpo_pkg;
  // ==========================================================
  // Register map.
  localparam logic [7:0] MPO_OFF_FUNC_SEL = 8'h00;
  localparam logic [7:0] MPO_OFF_TIMER_START = 8'h04;
  localparam logic [7:0] MPO_OFF_TIMER_STOP = 8'h08;
  localparam logic [7:0] MPO_OFF_LATCH_ASSERT = 8'h0c;
  localparam logic [7:0] MPO_OFF_LATCH_NEGATE = 8'h10;
  localparam logic [7:0] MPO_OFF_CHAN_A_MODE_FIRST = 8'h14;
  localparam logic [7:0] MPO_OFF_CHAN_A_MODE_SECOND = 8'h18;
  localparam logic [7:0] MPO_OFF_CHAN_B_MODE_FIRST = 8'h1c;
  localparam logic [7:0] MPO_OFF_CHAN_B_MODE_SECOND = 8'h20;
  localparam logic [7:0] MPO_OFF_CHAN_A_COMMAND = 8'h24;
  localparam logic [7:0] MPO_OFF_STATUS = 8'h28;
  // ==========================================================
  // Reset values and field positions.
  localparam logic [7:0] MPO_FUNC_SEL_RST = 8'h00;
  localparam logic [7:0] MPO_LATCH_RST = 8'h00;
  localparam logic [7:0] MPO_MODE_RST = 8'h00;
  localparam logic [7:0] MPO_PINS_RST = 8'hff;
  localparam int MPO_MODE_FIRST_RTS_BIT = 7;
  localparam int MPO_MODE_SECOND_RTS_BIT = 5;
  localparam logic [3:0] MPO_CMD_RTS_ASSERT = 4'h8;
  localparam logic [3:0] MPO_CMD_RTS_NEGATE = 4'h9;
  localparam logic [7:0] MPO_AUTO_RTS_8N = 8'h93;
  localparam int MPO_ISR_TXA = 0;
  localparam int MPO_ISR_RXA = 1;
  localparam int MPO_ISR_TXB = 4;
  localparam int MPO_ISR_RXB = 5;
  localparam logic [1:0] MPO_SEL_LATCH = 2'h0;
  localparam logic [1:0] MPO_SEL_ALT1 = 2'h1;
  localparam logic [1:0] MPO_SEL_ALT2 = 2'h2;
  localparam logic [1:0] MPO_SEL_ALT3 = 2'h3;
  localparam logic [1:0] MPO_HTRANS_NONSEQ = 2'h2;

  // Channel side signals sampled from the UART core.
  typedef struct packed {
    logic tx_a_x16;
    logic tx_a_x1;
    logic rx_a_x1;
    logic tx_b_x1;
    logic rx_b_x1;
    logic tmr_out;
    logic tc_reached;
    logic tmr_mode;
    logic [7:0] interrupt_status;
  } mpo_chan_s;
endpackage

// [hdl/mpo_port.sv]
// Purpose: Eight multipurpose output pins of a dual UART with AHB-Lite registers.
// Assumes: Channel inputs come from the same clock domain; pins are plain outputs.
// Notes: Pin value 1 is high; an asserted latch drives its pin low.
//   Pins are registered, so every pin lags its cause by one clock; this keeps
//   glitches from the channel clock muxes off the package pins at the cost of
//   one cycle of delay. Set and clear writes are masked per pin with the
//   alternate-function map that stands in the data phase of the write.
`timescale 1ns/1ns
`default_nettype none
module mpo_port (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire mpo_pkg::mpo_chan_s CHAN,
  input wire logic CHAN_A_AUTO_RTS_N,
  input wire logic CHAN_B_AUTO_RTS_N,
  output logic TIMER_START,
  output logic TIMER_STOP,
  output logic [7:0] OUT_PIN
);
  // ==========================================================
  // State.
  typedef struct packed {
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [7:0] func_sel;
    logic [7:0] latch;
    logic [7:0] mode_a1;
    logic [7:0] mode_a2;
    logic [7:0] mode_b1;
    logic [7:0] mode_b2;
    logic rts_a;
    logic cnt_low;
    logic start_p;
    logic stop_p;
    logic [31:0] rdata;
    logic [7:0] pins;
  } mpo_state_s;

  mpo_state_s state_ff;
  mpo_state_s nxt_state;
  logic [7:0] alt_mask;
  logic [7:0] alt_val;
  logic rd_take;
  logic [7:0] wd;

  // Alternate-function flag for a channel: either mode bit routes the pin.
  function automatic logic pin_alt(input logic [7:0] m1, input logic [7:0] m2);
    pin_alt = m1[mpo_pkg::MPO_MODE_FIRST_RTS_BIT] | m2[mpo_pkg::MPO_MODE_SECOND_RTS_BIT];
  endfunction

  // Write bits that may reach latches: pins on alternate functions are dropped.
  function automatic logic [7:0] free_bits(input logic [7:0] d, input logic [7:0] m);
    free_bits = d & ~m;
  endfunction

  // ==========================================================
  // Pin routing. Every pin that is not on its latch is masked from set/clear.
  always_comb begin
    alt_mask = 8'h00;
    alt_val = 8'hff;
    alt_mask[0] = pin_alt(state_ff.mode_a1, state_ff.mode_a2);
    alt_mask[1] = pin_alt(state_ff.mode_b1, state_ff.mode_b2);
    // Auto request-to-send from the channel wins over the command bit when enabled.
    alt_val[0] = state_ff.mode_a1[mpo_pkg::MPO_MODE_FIRST_RTS_BIT] ?
                 CHAN_A_AUTO_RTS_N : ~state_ff.rts_a;
    alt_val[1] = CHAN_B_AUTO_RTS_N;
    alt_mask[2] = state_ff.func_sel[1:0] != mpo_pkg::MPO_SEL_LATCH;
    unique case (state_ff.func_sel[1:0])
      mpo_pkg::MPO_SEL_LATCH: alt_val[2] = 1'b1;
      mpo_pkg::MPO_SEL_ALT1: alt_val[2] = CHAN.tx_a_x16;
      mpo_pkg::MPO_SEL_ALT2: alt_val[2] = CHAN.tx_a_x1;
      default: alt_val[2] = CHAN.rx_a_x1;
    endcase
    alt_mask[3] = state_ff.func_sel[3:2] != mpo_pkg::MPO_SEL_LATCH;
    unique case (state_ff.func_sel[3:2])
      mpo_pkg::MPO_SEL_LATCH: alt_val[3] = 1'b1;
      // Counter mode shows a level held low from terminal count until stop.
      mpo_pkg::MPO_SEL_ALT1: alt_val[3] = CHAN.tmr_mode ? CHAN.tmr_out : ~state_ff.cnt_low;
      mpo_pkg::MPO_SEL_ALT2: alt_val[3] = CHAN.tx_b_x1;
      default: alt_val[3] = CHAN.rx_b_x1;
    endcase
    alt_mask[7:4] = state_ff.func_sel[7:4];
    alt_val[4] = ~CHAN.interrupt_status[mpo_pkg::MPO_ISR_RXA];
    alt_val[5] = ~CHAN.interrupt_status[mpo_pkg::MPO_ISR_RXB];
    alt_val[6] = ~CHAN.interrupt_status[mpo_pkg::MPO_ISR_TXA];
    alt_val[7] = ~CHAN.interrupt_status[mpo_pkg::MPO_ISR_TXB];
  end

  assign rd_take = HSEL && HREADY && HTRANS == mpo_pkg::MPO_HTRANS_NONSEQ && !HWRITE;
  assign wd = HWDATA[7:0];

  // ==========================================================
  // Next-state logic: bus phases, register writes, timer commands, pins.
  always_comb begin
    nxt_state = state_ff;
    nxt_state.start_p = 1'b0;
    nxt_state.stop_p = 1'b0;
    // Data phase of a write lands one cycle after its address phase.
    if (state_ff.ph_valid && state_ff.ph_write) begin
      unique case (state_ff.ph_addr)
        mpo_pkg::MPO_OFF_FUNC_SEL: nxt_state.func_sel = wd;
        // Masked so writes never reach pins on alternate functions.
        mpo_pkg::MPO_OFF_LATCH_ASSERT: nxt_state.latch = state_ff.latch | free_bits(wd, alt_mask);
        mpo_pkg::MPO_OFF_LATCH_NEGATE: nxt_state.latch = state_ff.latch & ~free_bits(wd, alt_mask);
        mpo_pkg::MPO_OFF_CHAN_A_MODE_FIRST: nxt_state.mode_a1 = wd;
        mpo_pkg::MPO_OFF_CHAN_A_MODE_SECOND: nxt_state.mode_a2 = wd;
        mpo_pkg::MPO_OFF_CHAN_B_MODE_FIRST: nxt_state.mode_b1 = wd;
        mpo_pkg::MPO_OFF_CHAN_B_MODE_SECOND: nxt_state.mode_b2 = wd;
        mpo_pkg::MPO_OFF_CHAN_A_COMMAND: begin
          if (wd[7:4] == mpo_pkg::MPO_CMD_RTS_ASSERT) begin
            nxt_state.rts_a = 1'b1;
          end else if (wd[7:4] == mpo_pkg::MPO_CMD_RTS_NEGATE) begin
            nxt_state.rts_a = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    nxt_state.ph_valid = HSEL && HREADY && HTRANS == mpo_pkg::MPO_HTRANS_NONSEQ;
    nxt_state.ph_write = HWRITE;
    nxt_state.ph_addr = HADDR[7:0];
    // Reads are decoded in the address phase so data stands in the data phase.
    nxt_state.rdata = 32'h0000_0000;
    if (rd_take) begin
      unique case (HADDR[7:0])
        mpo_pkg::MPO_OFF_TIMER_START: nxt_state.start_p = 1'b1;
        mpo_pkg::MPO_OFF_TIMER_STOP: nxt_state.stop_p = 1'b1;
        mpo_pkg::MPO_OFF_STATUS: nxt_state.rdata = {16'h0000, state_ff.pins, state_ff.latch};
        mpo_pkg::MPO_OFF_CHAN_A_MODE_FIRST: nxt_state.rdata = {24'h000000, state_ff.mode_a1};
        mpo_pkg::MPO_OFF_CHAN_A_MODE_SECOND: nxt_state.rdata = {24'h000000, state_ff.mode_a2};
        mpo_pkg::MPO_OFF_CHAN_B_MODE_FIRST: nxt_state.rdata = {24'h000000, state_ff.mode_b1};
        mpo_pkg::MPO_OFF_CHAN_B_MODE_SECOND: nxt_state.rdata = {24'h000000, state_ff.mode_b2};
        default: nxt_state.rdata = 32'h0000_0000;
      endcase
    end
    // Counter output falls at terminal count; a stop wins and raises it again.
    if (state_ff.stop_p) begin
      nxt_state.cnt_low = 1'b0;
    end else if (CHAN.tc_reached && !CHAN.tmr_mode) begin
      nxt_state.cnt_low = 1'b1;
    end
    // Latched pins are low while their latch is asserted.
    nxt_state.pins = (alt_mask & alt_val) | (~alt_mask & ~state_ff.latch);
  end

  // ==========================================================
  // State register; reset leaves every pin high.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= '0;
      state_ff.func_sel <= mpo_pkg::MPO_FUNC_SEL_RST;
      state_ff.latch <= mpo_pkg::MPO_LATCH_RST;
      state_ff.mode_a1 <= mpo_pkg::MPO_MODE_RST;
      state_ff.pins <= mpo_pkg::MPO_PINS_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign HRDATA = state_ff.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign TIMER_START = state_ff.start_p;
  assign TIMER_STOP = state_ff.stop_p;
  assign OUT_PIN = state_ff.pins;

  // ==========================================================
  // Checks.
  set_drives_low_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state_ff.ph_valid && state_ff.ph_write && state_ff.ph_addr == mpo_pkg::MPO_OFF_LATCH_ASSERT
     && state_ff.func_sel[4] == 1'b0 && wd[4]) |=> state_ff.latch[4])
    else $error("set write did not assert latch four");
  latch_holds_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state_ff.latch[5] && !(state_ff.ph_valid && state_ff.ph_write
     && state_ff.ph_addr == mpo_pkg::MPO_OFF_LATCH_NEGATE)) |=> state_ff.latch[5])
    else $error("asserted latch dropped without clear write");
  clear_drives_high_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state_ff.ph_valid && state_ff.ph_write && state_ff.ph_addr == mpo_pkg::MPO_OFF_LATCH_NEGATE
     && !alt_mask[6] && wd[6]) |=> !state_ff.latch[6])
    else $error("clear write did not negate latch six");
  alt_protect_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (alt_mask[7] && $stable(alt_mask[7])) |=> $stable(state_ff.latch[7]))
    else $error("latch of alternate pin changed");
  rx_ready_pin_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state_ff.func_sel[4] && $stable(state_ff.func_sel[4])) |=>
    OUT_PIN[4] == !$past(CHAN.interrupt_status[mpo_pkg::MPO_ISR_RXA]))
    else $error("pin four not inverted receive ready");
  tx_ready_pin_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    state_ff.func_sel[6] |=> OUT_PIN[6] == !$past(CHAN.interrupt_status[mpo_pkg::MPO_ISR_TXA]))
    else $error("pin six not inverted transmit ready");
  start_read_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (rd_take && HADDR[7:0] == mpo_pkg::MPO_OFF_TIMER_START) |=> TIMER_START ##1 !TIMER_START)
    else $error("start read gave no single start pulse");
  stop_read_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (rd_take && HADDR[7:0] == mpo_pkg::MPO_OFF_TIMER_STOP) |=> TIMER_STOP)
    else $error("stop read gave no stop pulse");
  count_low_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state_ff.cnt_low && !state_ff.stop_p) |=> state_ff.cnt_low)
    else $error("counter output rose without stop");

  // ==========================================================
  // Pin routing checks; each pin lags its source by one clock.

  // Pin two on its latch shows the inverted latch.
  pin2_latch_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    state_ff.func_sel[1:0] == mpo_pkg::MPO_SEL_LATCH |=> OUT_PIN[2] == !$past(state_ff.latch[2]))
    else $error("pin two not on its latch");

  // Pin two shows the channel A transmit 16x clock.
  pin2_fast_clk_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    state_ff.func_sel[1:0] == mpo_pkg::MPO_SEL_ALT1 |=> OUT_PIN[2] == $past(CHAN.tx_a_x16))
    else $error("pin two not on transmit 16x clock");

  // Pin two shows the channel A transmit 1x clock.
  pin2_tx_clk_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    state_ff.func_sel[1:0] == mpo_pkg::MPO_SEL_ALT2 |=> OUT_PIN[2] == $past(CHAN.tx_a_x1))
    else $error("pin two not on transmit 1x clock");

  // Pin two shows the channel A receive 1x clock.
  pin2_rx_clk_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    state_ff.func_sel[1:0] == mpo_pkg::MPO_SEL_ALT3 |=> OUT_PIN[2] == $past(CHAN.rx_a_x1))
    else $error("pin two not on receive 1x clock");

  // Pin three on its latch shows the inverted latch.
  pin3_latch_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    state_ff.func_sel[3:2] == mpo_pkg::MPO_SEL_LATCH |=> OUT_PIN[3] == !$past(state_ff.latch[3]))
    else $error("pin three not on its latch");

  // Timer mode passes the square wave straight out.
  pin3_timer_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state_ff.func_sel[3:2] == mpo_pkg::MPO_SEL_ALT1 && CHAN.tmr_mode) |=>
    OUT_PIN[3] == $past(CHAN.tmr_out))
    else $error("pin three not on timer output");

  // Counter mode shows the held level.
  pin3_count_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state_ff.func_sel[3:2] == mpo_pkg::MPO_SEL_ALT1 && !CHAN.tmr_mode) |=>
    OUT_PIN[3] == !$past(state_ff.cnt_low))
    else $error("pin three not on counter level");

  // Pin three shows the channel B transmit 1x clock.
  pin3_tx_clk_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    state_ff.func_sel[3:2] == mpo_pkg::MPO_SEL_ALT2 |=> OUT_PIN[3] == $past(CHAN.tx_b_x1))
    else $error("pin three not on channel B transmit clock");

  // Pin three shows the channel B receive 1x clock.
  pin3_rx_clk_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    state_ff.func_sel[3:2] == mpo_pkg::MPO_SEL_ALT3 |=> OUT_PIN[3] == $past(CHAN.rx_b_x1))
    else $error("pin three not on channel B receive clock");

  // Pin four on its latch shows the inverted latch.
  pin4_latch_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !state_ff.func_sel[4] |=> OUT_PIN[4] == !$past(state_ff.latch[4]))
    else $error("pin four not on its latch");

  // Pin five shows inverted receive ready of channel B.
  rxb_pin_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    state_ff.func_sel[5] |=> OUT_PIN[5] == !$past(CHAN.interrupt_status[mpo_pkg::MPO_ISR_RXB]))
    else $error("pin five not inverted receive ready");

  // Pin seven shows inverted transmit ready of channel B.
  txb_pin_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    state_ff.func_sel[7] |=> OUT_PIN[7] == !$past(CHAN.interrupt_status[mpo_pkg::MPO_ISR_TXB]))
    else $error("pin seven not inverted transmit ready");

  // Pin seven on its latch shows the inverted latch.
  pin7_latch_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !state_ff.func_sel[7] |=> OUT_PIN[7] == !$past(state_ff.latch[7]))
    else $error("pin seven not on its latch");

  // ==========================================================
  // Counter level and command pulse checks.

  // Terminal count in counter mode pulls the level low.
  count_fall_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (CHAN.tc_reached && !CHAN.tmr_mode && !state_ff.stop_p) |=> state_ff.cnt_low)
    else $error("terminal count did not pull counter level low");

  // A stop command always raises the level again.
  count_rise_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    state_ff.stop_p |=> !state_ff.cnt_low)
    else $error("stop command did not raise counter level");

  // A start pulse only ever follows a start read.
  start_cause_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    TIMER_START |-> $past(rd_take && HADDR[7:0] == mpo_pkg::MPO_OFF_TIMER_START))
    else $error("start pulse without start read");

  // A stop pulse only ever follows a stop read.
  stop_cause_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    TIMER_STOP |-> $past(rd_take && HADDR[7:0] == mpo_pkg::MPO_OFF_TIMER_STOP))
    else $error("stop pulse without stop read");

  // ==========================================================
  // Register and pin zero/one checks.

  // A set or clear write leaves an alternate-function latch alone.
  pin2_protect_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state_ff.ph_valid && state_ff.ph_write && alt_mask[2]) |=>
    state_ff.latch[2] == $past(state_ff.latch[2]))
    else $error("latch of pin two changed on alternate function");

  // The status read returns the latch byte.
  status_read_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (rd_take && HADDR[7:0] == mpo_pkg::MPO_OFF_STATUS) |=>
    HRDATA[7:0] == $past(state_ff.latch))
    else $error("status read lost the latch byte");

  // A mode write is stored whole.
  mode_store_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state_ff.ph_valid && state_ff.ph_write
     && state_ff.ph_addr == mpo_pkg::MPO_OFF_CHAN_A_MODE_FIRST) |=> state_ff.mode_a1 == $past(wd))
    else $error("mode write not stored");

  // Command code eight asserts request-to-send.
  rts_on_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state_ff.ph_valid && state_ff.ph_write && state_ff.ph_addr == mpo_pkg::MPO_OFF_CHAN_A_COMMAND
     && wd[7:4] == mpo_pkg::MPO_CMD_RTS_ASSERT) |=> state_ff.rts_a)
    else $error("assert command did not set request-to-send");

  // Command code nine negates request-to-send.
  rts_off_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state_ff.ph_valid && state_ff.ph_write && state_ff.ph_addr == mpo_pkg::MPO_OFF_CHAN_A_COMMAND
     && wd[7:4] == mpo_pkg::MPO_CMD_RTS_NEGATE) |=> !state_ff.rts_a)
    else $error("negate command did not clear request-to-send");

  // Automatic request-to-send drives pin zero.
  pin0_auto_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    state_ff.mode_a1[mpo_pkg::MPO_MODE_FIRST_RTS_BIT] |=> OUT_PIN[0] == $past(CHAN_A_AUTO_RTS_N))
    else $error("pin zero not on automatic request-to-send");

  // Command-driven request-to-send drives pin zero low while set.
  pin0_cmd_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (!state_ff.mode_a1[mpo_pkg::MPO_MODE_FIRST_RTS_BIT]
     && state_ff.mode_a2[mpo_pkg::MPO_MODE_SECOND_RTS_BIT]) |=> OUT_PIN[0] == !$past(state_ff.rts_a))
    else $error("pin zero not on command request-to-send");

  // Pin zero off its alternate function follows its latch.
  pin0_latch_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !alt_mask[0] |=> OUT_PIN[0] == !$past(state_ff.latch[0]))
    else $error("pin zero not on its latch");

  // Pin one on its alternate function follows channel B.
  pin1_auto_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    alt_mask[1] |=> OUT_PIN[1] == $past(CHAN_B_AUTO_RTS_N))
    else $error("pin one not on channel B request-to-send");

  // The first edge after reset shows every pin high.
  reset_pins_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(ARST_N) |-> (OUT_PIN == mpo_pkg::MPO_PINS_RST && state_ff.func_sel == 8'h00))
    else $error("pins not high after reset");
endmodule // mpo_port
`default_nettype wire

// [verification/mpo_pin_load.sv]
// Purpose: Load on the eight output pins that remembers which pins went high.
// Assumes: Pins are push-pull outputs, so no pull resistor is modelled.
// Notes: CLR starts a fresh watch window; the record is sticky in between.
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Pin load model
module mpo_pin_load (
  input wire logic CLK,
  input wire logic CLR,
  input wire logic [7:0] PINS,
  output logic [7:0] HIGH_SEEN
);
  // Sticky so that a one-cycle glitch high is not lost between two checks.
  always_ff @(posedge CLK) begin
    HIGH_SEEN <= CLR ? 8'h00 : (HIGH_SEEN | PINS);
  end
endmodule // mpo_pin_load
`default_nettype wire

// [verification/tb_mpo_port.sv]
// Purpose: Self-checking bench for the multipurpose output port.
// Assumes: Zero-wait slave; a pin follows its cause within two cycles.
// Notes: A reference model of registers and pins is compared at each result.
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Bench top
module tb_mpo_port;
  logic clk, hsel, hwrite, rdy, hresp, st, sp, t_start, t_stop, clr, a_rts_n, b_rts_n;
  logic arst_n;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, r;
  logic [7:0] pins, high_seen;
  logic [7:0] fsel = '0, latch = '0, m1a = '0, m2a = '0, m1b = '0;
  logic tcf = 1'b0, cmda = 1'b0;
  mpo_pkg::mpo_chan_s chan, cs;
  int bad_count = 0, num_checks = 0, cycles = 0;
  mpo_port mpo_port_i (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy),
    .HRDATA(hrdata), .HREADYOUT(rdy), .HRESP(hresp), .CHAN(chan), .CHAN_A_AUTO_RTS_N(a_rts_n),
    .CHAN_B_AUTO_RTS_N(b_rts_n), .TIMER_START(t_start), .TIMER_STOP(t_stop), .OUT_PIN(pins));
  mpo_pin_load mpo_pin_load_i (.CLK(clk), .CLR(clr), .PINS(pins), .HIGH_SEEN(high_seen));
  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard; the whole run needs well under two thousand cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  // ==========================================================
  // Reference model and helpers
  function automatic logic [7:0] alt();
    return {fsel[7:4], |fsel[3:2], |fsel[1:0], m1b[7], m1a[7] | m2a[5]};
  endfunction
  function automatic logic [7:0] exp_pins();
    logic [7:0] p;
    p = ~latch;
    case (fsel[1:0])
      2'h1: p[2] = chan.tx_a_x16;
      2'h2: p[2] = chan.tx_a_x1;
      2'h3: p[2] = chan.rx_a_x1;
      default: ;
    endcase
    case (fsel[3:2])
      2'h1: p[3] = chan.tmr_mode ? chan.tmr_out : ~tcf;
      2'h2: p[3] = chan.tx_b_x1;
      2'h3: p[3] = chan.rx_b_x1;
      default: ;
    endcase
    p[7:4] = (fsel[7:4] & ~{chan.interrupt_status[4], chan.interrupt_status[0], chan.interrupt_status[5], chan.interrupt_status[1]})
      | (~fsel[7:4] & p[7:4]);
    if (m1a[7]) p[0] = a_rts_n;
    else if (m2a[5]) p[0] = ~cmda;
    if (m1b[7]) p[1] = b_rts_n;
    return p;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One single AHB-Lite transfer; the model follows each completed write.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= mpo_pkg::MPO_HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
    {st, sp} = {t_start, t_stop};
    if (!wr && a == mpo_pkg::MPO_OFF_TIMER_STOP) tcf = 1'b0;
    if (wr) begin
      case (a)
        mpo_pkg::MPO_OFF_FUNC_SEL: fsel = d[7:0];
        mpo_pkg::MPO_OFF_LATCH_ASSERT: latch = latch | (d[7:0] & ~alt());
        mpo_pkg::MPO_OFF_LATCH_NEGATE: latch = latch & ~(d[7:0] & ~alt());
        mpo_pkg::MPO_OFF_CHAN_A_MODE_FIRST: m1a = d[7:0];
        mpo_pkg::MPO_OFF_CHAN_A_MODE_SECOND: m2a = d[7:0];
        mpo_pkg::MPO_OFF_CHAN_B_MODE_FIRST: m1b = d[7:0];
        mpo_pkg::MPO_OFF_CHAN_A_COMMAND: if (d[7:5] == 3'h4) cmda = ~d[4];
        default: ;
      endcase
    end
  endtask
  task automatic pin_chk();
    repeat (2) @(posedge clk);
    #1;
    chk({24'h0, pins}, {24'h0, exp_pins()});
  endtask
  // Random channel side, terminal count kept quiet.
  task automatic shake();
    r = $urandom;
    cs = mpo_pkg::mpo_chan_s'(r[15:0]);
    cs.tc_reached = 1'b0;
    @(posedge clk);
    chan <= cs;
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {arst_n, hsel, hwrite, htrans, haddr, hwdata, chan, clr, a_rts_n, b_rts_n} = '0;
    void'($urandom(32'hfab0));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    pin_chk();
    bus(1'b0, mpo_pkg::MPO_OFF_FUNC_SEL, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 8'h3c, 32'hff);
    bus(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h0);
    $display("Test reset done");
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      bus(1'b1, mpo_pkg::MPO_OFF_LATCH_ASSERT, r);
      pin_chk();
      bus(1'b1, mpo_pkg::MPO_OFF_LATCH_NEGATE, r >> 8);
      bus(1'b0, mpo_pkg::MPO_OFF_STATUS, 32'h0);
      chk(rd & 32'hff, {24'h0, latch});
    end
    bus(1'b1, mpo_pkg::MPO_OFF_LATCH_ASSERT, 32'hf0);
    pin_chk();
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    bus(1'b1, mpo_pkg::MPO_OFF_LATCH_NEGATE, 32'h0f);
    bus(1'b0, mpo_pkg::MPO_OFF_TIMER_STOP, 32'h0);
    pin_chk();
    chk({24'h0, high_seen & 8'hf0}, 32'h0);
    $display("Test latches done");
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      bus(1'b1, mpo_pkg::MPO_OFF_FUNC_SEL, {r[31:8], r[7:4], i[1:0], i[3:2]});
      bus(1'b1, mpo_pkg::MPO_OFF_LATCH_ASSERT, r >> 8);
      bus(1'b1, mpo_pkg::MPO_OFF_LATCH_NEGATE, r >> 16);
      repeat (3) begin
        shake();
        pin_chk();
      end
    end
    $display("Test functions done");
    bus(1'b0, mpo_pkg::MPO_OFF_TIMER_START, 32'h0);
    chk({30'h0, st, sp}, 32'h2);
    bus(1'b1, mpo_pkg::MPO_OFF_FUNC_SEL, 32'h04);
    cs = '0;
    cs.tc_reached = 1'b1;
    @(posedge clk) chan <= cs;
    @(posedge clk) chan <= '0;
    tcf = 1'b1;
    repeat (3) pin_chk();
    bus(1'b0, mpo_pkg::MPO_OFF_TIMER_STOP, 32'h0);
    chk({30'h0, st, sp}, 32'h1);
    pin_chk();
    $display("Test counter done");
    @(posedge clk) arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    {fsel, latch, m1a, m2a, m1b, tcf, cmda} = '0;
    pin_chk();
    bus(1'b0, mpo_pkg::MPO_OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_ff00);
    $display("Test second reset done");
    bus(1'b1, mpo_pkg::MPO_OFF_CHAN_A_MODE_FIRST, 32'h93);
    bus(1'b1, mpo_pkg::MPO_OFF_CHAN_B_MODE_FIRST, 32'h80);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) {a_rts_n, b_rts_n} <= i[1:0];
      bus(1'b1, mpo_pkg::MPO_OFF_LATCH_ASSERT, 32'h03);
      pin_chk();
    end
    bus(1'b1, mpo_pkg::MPO_OFF_CHAN_A_MODE_FIRST, 32'h0);
    bus(1'b1, mpo_pkg::MPO_OFF_CHAN_A_MODE_SECOND, 32'h20);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, mpo_pkg::MPO_OFF_CHAN_A_COMMAND, i[0] ? 32'h90 : 32'h80);
      pin_chk();
    end
    $display("Test pins zero and one done");
    final_report();
  end
endmodule // tb_mpo_port
`default_nettype wire
